/* logic/pxp_expander.sv */
// serial port expander: two-wire slave, ports, blink, pwm and transition detect
`timescale 1ns/100ps
`include "pxp_regs.svh"
module pxp_expander (
    // clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    // two-wire bus
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // address strap, 0 gnd 1 supply 2 clock line 3 data line
    input  wire logic [1:0]  address_select_pin,
    // ports
    input  wire logic [15:0] io_port_pins_in,
    output logic      [15:0] io_port_pins_out,
    output logic      [15:0] io_port_pins_oe,
    output logic             irq_or_extra_output_out,
    output logic             irq_or_extra_output_oe,
    input  wire logic        blink_in,
    // status
    output logic             standby
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [19:0] sy1_r;
    logic [19:0] sy2_r;
    logic        scl_d_r;
    logic        sda_d_r;
    logic [1:0]  sel1_r;
    logic [1:0]  sel2_r;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sy1_r   <= 20'hFFFFF;
            sy2_r   <= 20'hFFFFF;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            sel1_r  <= 2'h0;
            sel2_r  <= 2'h0;
        end else if (ce) begin
            sy1_r   <= {blink_in, scl_in, sda_in, 1'b0, io_port_pins_in};
            sy2_r   <= sy1_r;
            sel1_r  <= address_select_pin;
            sel2_r  <= sel1_r;
            scl_d_r <= sy2_r[18];
            sda_d_r <= sy2_r[17];
        end
    end
    wire logic [15:0] pin_lvl = sy2_r[15:0];
    wire logic        scl     = sy2_r[18];
    wire logic        sda     = sy2_r[17];
    wire logic        blink_l = sy2_r[19];
    wire logic        scl_rise = scl && !scl_d_r;
    wire logic        scl_fall = !scl && scl_d_r;
    wire logic        start_c  = scl && scl_d_r && sda_d_r && !sda;
    wire logic        stop_c   = scl && scl_d_r && !sda_d_r && sda;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] ph0_r [2];
    logic [7:0] ph1_r [2];
    logic [7:0] pcfg_r [2];
    logic [7:0] mst_r;
    logic [7:0] cfg_r;
    logic [7:0] inten_r [8];
    logic [7:0] snap_r [2];

    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        if (p >= `PXP_REG_INT_FIRST && p <= `PXP_REG_INT_LAST)
            next_ptr = (p == `PXP_REG_INT_LAST) ? `PXP_REG_INT_FIRST : p + 8'h01;
        else if (p == `PXP_REG_MASTER || p == `PXP_REG_CONFIG)
            next_ptr = p;
        else
            next_ptr = {p[7:1], ~p[0]};
    endfunction

    logic [15:0] pend;
    logic        irq_act;
    always_comb begin
        pend    = {pin_lvl[15:8] ^ snap_r[1], pin_lvl[7:0] ^ snap_r[0]};
        pend    = pend & {pcfg_r[1], pcfg_r[0]};
        irq_act = |pend;
    end

    function automatic logic [7:0] rd_reg(input logic [7:0] a);
        case (a)
            `PXP_REG_IN_LO:  rd_reg = pin_lvl[7:0];
            `PXP_REG_IN_HI:  rd_reg = pin_lvl[15:8];
            `PXP_REG_PH0_LO: rd_reg = ph0_r[0];
            `PXP_REG_PH0_HI: rd_reg = ph0_r[1];
            `PXP_REG_CFG_LO: rd_reg = pcfg_r[0];
            `PXP_REG_CFG_HI: rd_reg = pcfg_r[1];
            `PXP_REG_PH1_LO: rd_reg = ph1_r[0];
            `PXP_REG_PH1_HI: rd_reg = ph1_r[1];
            `PXP_REG_MASTER: rd_reg = mst_r;
            `PXP_REG_CONFIG: rd_reg = {blink_l, irq_act, cfg_r[5:0]};
            default: rd_reg = (a[7:3] == 5'h02) ? inten_r[a[2:0]] : 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    pxp_pkg::pxp_state_t st_r, st_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [3:0] bc_r, bc_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic       first_r, first_nxt;
    logic       rw_r, rw_nxt;
    logic       sdal_r, sdal_nxt;
    logic       wr_stb;
    logic       rd_stb;
    logic [6:0] my_addr;

    always_comb begin
        my_addr = `PXP_ADDR_FIXED;
        my_addr[`PXP_ADDR_HI_BIT] = sel2_r[1];
        my_addr[`PXP_ADDR_LO_BIT] = sel2_r[0];
    end

    always_comb begin
        st_nxt    = st_r;
        sh_nxt    = sh_r;
        bc_nxt    = bc_r;
        ptr_nxt   = ptr_r;
        first_nxt = first_r;
        rw_nxt    = rw_r;
        sdal_nxt  = sdal_r;
        wr_stb    = 1'b0;
        rd_stb    = 1'b0;
        if (start_c) begin
            st_nxt   = pxp_pkg::PXP_ADDR;
            bc_nxt   = 4'h0;
            sdal_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt   = pxp_pkg::PXP_IDLE;
            sdal_nxt = 1'b0;
        end else begin
            case (st_r)
                pxp_pkg::PXP_IDLE: sdal_nxt = 1'b0;
                pxp_pkg::PXP_ADDR, pxp_pkg::PXP_RXB: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda};
                        bc_nxt = bc_r + 4'h1;
                    end
                    if (scl_fall && bc_r == 4'h8) begin
                        bc_nxt = 4'h0;
                        if (st_r == pxp_pkg::PXP_ADDR) begin
                            if (sh_r[7:1] == my_addr) begin
                                rw_nxt    = sh_r[0];
                                first_nxt = 1'b1;
                                sdal_nxt  = 1'b1;
                                st_nxt    = pxp_pkg::PXP_ACKW;
                            end else begin
                                st_nxt = pxp_pkg::PXP_IDLE;
                            end
                        end else begin
                            sdal_nxt = 1'b1;
                            st_nxt   = pxp_pkg::PXP_ACKW;
                            if (first_r) begin
                                ptr_nxt   = sh_r;
                                first_nxt = 1'b0;
                            end else begin
                                wr_stb  = 1'b1;
                                ptr_nxt = next_ptr(ptr_r);
                            end
                        end
                    end
                end
                pxp_pkg::PXP_ACKW: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            sh_nxt   = rd_reg(ptr_r);
                            rd_stb   = 1'b1;
                            ptr_nxt  = next_ptr(ptr_r);
                            sdal_nxt = !sh_nxt[7];
                            bc_nxt   = 4'h1;
                            st_nxt   = pxp_pkg::PXP_TXB;
                        end else begin
                            sdal_nxt = 1'b0;
                            st_nxt   = pxp_pkg::PXP_RXB;
                        end
                    end
                end
                pxp_pkg::PXP_TXB: begin
                    if (scl_fall) begin
                        if (bc_r == 4'h8) begin
                            sdal_nxt = 1'b0;
                            st_nxt   = pxp_pkg::PXP_ACKR;
                        end else begin
                            sdal_nxt = !sh_r[3'(4'h7 - bc_r)];
                            bc_nxt   = bc_r + 4'h1;
                        end
                    end
                end
                pxp_pkg::PXP_ACKR: begin
                    if (scl_rise) begin
                        if (sda) st_nxt = pxp_pkg::PXP_IDLE;
                        else     st_nxt = pxp_pkg::PXP_ACKW;
                    end
                end
                default: st_nxt = pxp_pkg::PXP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r    <= pxp_pkg::PXP_IDLE;
            sh_r    <= 8'h00;
            bc_r    <= 4'h0;
            ptr_r   <= 8'h00;
            first_r <= 1'b0;
            rw_r    <= 1'b0;
            sdal_r  <= 1'b0;
        end else if (ce) begin
            st_r    <= st_nxt;
            sh_r    <= sh_nxt;
            bc_r    <= bc_nxt;
            ptr_r   <= ptr_nxt;
            first_r <= first_nxt;
            rw_r    <= rw_nxt;
            sdal_r  <= sdal_nxt;
        end
    end

    // ------------------------------------------------------------
    // register writes and input snapshot
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ph0_r[0]  <= `PXP_RST_PORT;
            ph0_r[1]  <= `PXP_RST_PORT;
            ph1_r[0]  <= `PXP_RST_PORT;
            ph1_r[1]  <= `PXP_RST_PORT;
            pcfg_r[0] <= `PXP_RST_PORT;
            pcfg_r[1] <= `PXP_RST_PORT;
            mst_r     <= `PXP_RST_MASTER;
            cfg_r     <= `PXP_RST_CONFIG;
            snap_r[0] <= 8'hFF;
            snap_r[1] <= 8'hFF;
            for (int i = 0; i < 8; i++) inten_r[i] <= `PXP_RST_INTENS;
        end else if (ce) begin
            if (rd_stb && ptr_r == `PXP_REG_IN_LO) snap_r[0] <= pin_lvl[7:0];
            if (rd_stb && ptr_r == `PXP_REG_IN_HI) snap_r[1] <= pin_lvl[15:8];
            if (wr_stb) begin
                case (ptr_r)
                    `PXP_REG_PH0_LO: ph0_r[0]  <= sh_r;
                    `PXP_REG_PH0_HI: ph0_r[1]  <= sh_r;
                    `PXP_REG_CFG_LO: pcfg_r[0] <= sh_r;
                    `PXP_REG_CFG_HI: pcfg_r[1] <= sh_r;
                    `PXP_REG_PH1_LO: ph1_r[0]  <= sh_r;
                    `PXP_REG_PH1_HI: ph1_r[1]  <= sh_r;
                    `PXP_REG_MASTER: mst_r     <= sh_r;
                    `PXP_REG_CONFIG: cfg_r     <= {2'b00, sh_r[5:0]};
                    default: if (ptr_r[7:3] == 5'h02) inten_r[ptr_r[2:0]] <= sh_r;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // pwm and output drive
    // ------------------------------------------------------------
    wire logic [3:0] master  = mst_r[7:4];
    wire logic       pwm_on  = master != 4'h0;
    logic [7:0] slot;
    pxp_pwm u_pwm (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .run   (pwm_on),
        .slot  (slot),
        .tick  ()
    );

    // duty in slots of 240: master window of 16 slots each, scaled by level when PXP_CFG_GLOBAL is clear
    function automatic logic pwm_bit(input logic [3:0] lvl, input logic [7:0] sl);
        logic [7:0] win;
        logic [7:0] hi;
        win = {master, 4'h0};
        if (cfg_r[`PXP_CFG_GLOBAL])
            hi = {master, mst_r[3:0]};
        else
            hi = {4'h0, lvl} * {4'h0, master};
        pwm_bit = (sl < hi) && (sl < win);
    endfunction

    logic [16:0] phase_q;
    logic [16:0] drive;
    logic        sel1;
    always_comb begin
        sel1 = cfg_r[`PXP_CFG_BLINK_EN] && (blink_l ^ cfg_r[`PXP_CFG_FLIP]);
        phase_q = sel1 ? {mst_r[3], ph1_r[1], ph1_r[0]}
                       : {mst_r[3], ph0_r[1], ph0_r[0]};
        for (int i = 0; i < 17; i++) begin
            logic [3:0] lv;
            lv = (i == 16) ? mst_r[3:0] : (i[0] ? inten_r[i >> 1][7:4] : inten_r[i >> 1][3:0]);
            if (pwm_on && lv != 4'hF && phase_q[i])
                drive[i] = pwm_bit(lv, slot);
            else
                drive[i] = phase_q[i];
        end
    end

    logic [16:0] out_r;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) out_r <= 17'h1FFFF;
        else if (ce) out_r <= drive;
    end

    assign io_port_pins_out        = 16'h0000;
    assign io_port_pins_oe         = ~out_r[15:0] & ~{pcfg_r[1], pcfg_r[0]};
    assign irq_or_extra_output_out = 1'b0;
    assign irq_or_extra_output_oe  = cfg_r[`PXP_CFG_INT_EN] ? irq_act
                                                            : !out_r[16];
    assign sda_out                 = 1'b0;
    assign sda_oe                  = sdal_r;
    assign standby = (st_r == pxp_pkg::PXP_IDLE) && !pwm_on;
endmodule

/* logic/pxp_pwm.sv */
// pwm intensity generator, ticks at the nominal oscillator rate
`timescale 1ns/100ps
`include "pxp_regs.svh"
module pxp_pwm (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    // control
    input  wire logic        run,
    // slot counter 0..239 and tick
    output logic      [7:0]  slot,
    output logic             tick
);
    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic [7:0]  slot_r;
    logic [7:0]  slot_nxt;

    always_comb begin
        div_nxt  = div_r;
        slot_nxt = slot_r;
        if (!run) begin
            div_nxt  = 16'h0000;
            slot_nxt = 8'h00;
        end else if (div_r == 16'(`PXP_PWM_DIV - 1)) begin
            div_nxt  = 16'h0000;
            slot_nxt = (slot_r == 8'hEF) ? 8'h00 : slot_r + 8'h01;
        end else begin
            div_nxt = div_r + 16'h0001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_r  <= 16'h0000;
            slot_r <= 8'h00;
        end else if (ce) begin
            div_r  <= div_nxt;
            slot_r <= slot_nxt;
        end
    end

    assign slot = slot_r;
    assign tick = run && (div_r == 16'(`PXP_PWM_DIV - 1));
endmodule

/* shared/pxp_pkg.sv */
// types shared by the serial port expander
package pxp_pkg;
    typedef enum logic [5:0] {
        PXP_IDLE = 6'b000001,
        PXP_ADDR = 6'b000010,
        PXP_ACKW = 6'b000100,
        PXP_RXB  = 6'b001000,
        PXP_TXB  = 6'b010000,
        PXP_ACKR = 6'b100000
    } pxp_state_t;
    // strap level of the address select pin
    typedef enum logic [1:0] {
        PXP_SEL_GND = 2'h0,
        PXP_SEL_VCC = 2'h1,
        PXP_SEL_SCL = 2'h2,
        PXP_SEL_SDA = 2'h3
    } pxp_sel_t;
endpackage

/* shared/pxp_regs.svh */
// register map, reset values and timing counts of the serial port expander
`ifndef PXP_REGS_SVH
`define PXP_REGS_SVH
`define PXP_REG_IN_LO      8'h00
`define PXP_REG_IN_HI      8'h01
`define PXP_REG_PH0_LO     8'h02
`define PXP_REG_PH0_HI     8'h03
`define PXP_REG_CFG_LO     8'h06
`define PXP_REG_CFG_HI     8'h07
`define PXP_REG_PH1_LO     8'h0A
`define PXP_REG_PH1_HI     8'h0B
`define PXP_REG_MASTER     8'h0E
`define PXP_REG_CONFIG     8'h0F
`define PXP_REG_INT_FIRST  8'h10
`define PXP_REG_INT_LAST   8'h17
`define PXP_RST_PORT       8'hFF
`define PXP_RST_MASTER     8'h0F
`define PXP_RST_CONFIG     8'h0C
`define PXP_RST_INTENS     8'hFF
// configuration register fields
`define PXP_CFG_BLINK_EN   0
`define PXP_CFG_FLIP       1
`define PXP_CFG_GLOBAL     2
`define PXP_CFG_INT_EN     3
`define PXP_CFG_INT_STAT   6
`define PXP_CFG_BLINK_STAT 7
// address fixed bits and strap bit positions
`define PXP_ADDR_FIXED     7'h20
`define PXP_ADDR_HI_BIT    6
`define PXP_ADDR_LO_BIT    2
// pwm timing: nominal oscillator frequency in hz, system clock in hz
`define PXP_PWM_HZ         32000
`define PXP_MCLK_HZ        250000000
`define PXP_PWM_DIV        (`PXP_MCLK_HZ / `PXP_PWM_HZ)
`endif

/* tb/pxp_i2c_mst.sv */
// two-wire bus master model facing the expander
`timescale 1ns/100ps
module pxp_i2c_mst (
    // clock
    input  wire logic mclk,
    // bus, data level already includes the slave pull-down
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // ------------------------------
    // bus phases, a quarter bit each
    // ------------------------------
    task automatic qw();
        repeat (8) @(negedge mclk);
    endtask
    // open low: data falls with clock high; open high: data rises with clock high
    task automatic frame(input logic open);
        qw();
        sda = ~open;
        qw();
        scl = 1'b1;
        qw();
        sda = open;
        qw();
        scl = open;
    endtask
    // data changes only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        qw();
        sda = b;
        qw();
        scl = 1'b1;
        qw();
        r = sda_line;
        qw();
        scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack_seen);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, ack_seen);
    endtask
endmodule

/* tb/pxp_sva.sv */
// pin-level assertions for the serial port expander
`timescale 1ns/100ps
module pxp_sva (
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // bus
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    // ports and status
    input wire logic        blink_in,
    input wire logic [15:0] io_port_pins_out,
    input wire logic [15:0] io_port_pins_oe,
    input wire logic        irq_or_extra_output_out,
    input wire logic        irq_or_extra_output_oe,
    input wire logic        standby
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence quiet_s;
        (standby && $stable(blink_in)) [*6];
    endsequence
    sequence start_s;
        scl_in && $fell(sda_in);
    endsequence
    a_rst_defaults: assert property (
        $fell(reset) |-> io_port_pins_oe == 16'h0 && !irq_or_extra_output_oe && standby)
        else $error("outputs not at power-up state");
    a_sda_open_drain: assert property (
        sda_out == 1'b0) else $error("data line driven high");
    a_port_open_drain: assert property (
        io_port_pins_out == 16'h0 && !irq_or_extra_output_out) else $error("port driven high");
    a_ack_scl_low: assert property (
        $rose(sda_oe) |-> !scl_in && !$past(scl_in)) else $error("drive began with clock high");
    a_sda_hold_high: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("data moved while clock high");
    a_idle_no_drive: assert property (
        standby |-> !sda_oe) else $error("data line driven while idle");
    a_start_wakes: assert property (
        start_s |-> ##[1:8] !standby) else $error("standby kept after start");
    a_static_quiet: assert property (
        quiet_s |=> $stable(io_port_pins_oe)) else $error("port moved in standby");
endmodule
bind pxp_expander pxp_sva u_sva (.mclk(mclk), .reset(reset), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .blink_in(blink_in),
    .io_port_pins_out(io_port_pins_out), .io_port_pins_oe(io_port_pins_oe),
    .irq_or_extra_output_out(irq_or_extra_output_out),
    .irq_or_extra_output_oe(irq_or_extra_output_oe), .standby(standby));

/* tb/tb_top.sv */
// self-checking bench for the serial port expander
`timescale 1ns/100ps
module tb_top;
    logic        mclk, reset, ce, blink, sda_out, sda_oe, irq_out, irq_oe, standby;
    logic [1:0]  sel;
    logic [6:0]  dev;
    logic [7:0]  r0, r1;
    logic [15:0] pins, pins_out, pins_oe;
    wire logic   scl, sda_m, sda_line;
    int          failures, checked;
    assign sda_line = sda_m & ~sda_oe;
    assign dev = {sel[1], 3'h4, sel[0], 2'h0};
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;
    pxp_i2c_mst u_mst (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(sda_m));
    pxp_expander u_dut (
        .mclk(mclk), .reset(reset), .ce(ce), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(sel),
        .io_port_pins_in(pins), .io_port_pins_out(pins_out), .io_port_pins_oe(pins_oe),
        .irq_or_extra_output_out(irq_out), .irq_or_extra_output_oe(irq_oe),
        .blink_in(blink), .standby(standby));
    // --------------
    // access tasks
    // --------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic send(input logic [7:0] b, input logic ack_exp);
        logic [7:0] q;
        logic       a;
        u_mst.xfer(b, 1'b1, q, a);
        check({15'h0, a}, {15'h0, ~ack_exp});
    endtask
    task automatic wr(input logic [7:0] cmd, d0, d1, d2, input int n);
        u_mst.frame(1'b0);
        send({dev, 1'b0}, 1'b1);
        send(cmd, 1'b1);
        if (n > 0) send(d0, 1'b1);
        if (n > 1) send(d1, 1'b1);
        if (n > 2) send(d2, 1'b1);
        u_mst.frame(1'b1);
    endtask
    task automatic rd(input logic [7:0] cmd, input logic setp, input int n);
        logic a;
        if (setp) wr(cmd, 8'h0, 8'h0, 8'h0, 0);
        u_mst.frame(1'b0);
        send({dev, 1'b1}, 1'b1);
        u_mst.xfer(8'hFF, n == 1, r0, a);
        if (n > 1) u_mst.xfer(8'hFF, 1'b1, r1, a);
        u_mst.frame(1'b1);
    endtask
    // --------------
    // test sequence
    // --------------
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        sel = 2'h0;
        pins = 16'hA55A;
        blink = 1'b1;
        failures = 0;
        checked = 0;
        cyc(5);
        reset = 1'b0;
        cyc(4);
        check(pins_oe, 16'h0);
        check({15'h0, standby}, 16'h1);
        for (int s = 3; s >= 0; s--) begin
            sel = s[1:0];
            cyc(4);
            wr(8'h00, 8'h0, 8'h0, 8'h0, 0);
            u_mst.frame(1'b0);
            send({dev ^ 7'h40, 1'b0}, 1'b0);
            u_mst.frame(1'b1);
        end
        rd(8'h00, 1'b1, 2);
        check({r1, r0}, 16'hA55A);
        rd(8'h0F, 1'b1, 2);
        check({r1, r0}, 16'h8C8C);
        rd(8'h0E, 1'b1, 1);
        check({8'h0, r0}, 16'h000F);
        check({15'h0, irq_oe}, 16'h0);
        ce = 1'b0;
        pins = 16'hA55B;
        cyc(8);
        check({15'h0, irq_oe}, 16'h0);
        ce = 1'b1;
        cyc(8);
        check({15'h0, irq_oe}, 16'h1);
        pins = 16'hA55A;
        cyc(8);
        check({15'h0, irq_oe}, 16'h0);
        pins = 16'hA55B;
        cyc(8);
        rd(8'h00, 1'b1, 1);
        check({7'h0, irq_oe, r0}, 16'h005B);
        wr(8'h00, 8'h12, 8'h0, 8'h0, 1);
        rd(8'h00, 1'b1, 1);
        check({8'h0, r0}, 16'h005B);
        wr(8'h0E, 8'h0, 8'h0, 8'h0, 0);
        rd(8'h0E, 1'b0, 1);
        check({8'h0, r0}, 16'h000F);
        wr(8'h02, 8'h0F, 8'hF0, 8'h33, 3);
        wr(8'h06, 8'h00, 8'h00, 8'h0, 2);
        check(pins_oe, 16'h0FCC);
        rd(8'h02, 1'b1, 2);
        check({r1, r0}, 16'hF033);
        wr(8'h0A, 8'hFF, 8'hFF, 8'h0, 2);
        check(pins_oe, 16'h0FCC);
        wr(8'h0F, 8'h0D, 8'h0, 8'h0, 1);
        check(pins_oe, 16'h0000);
        blink = 1'b0;
        cyc(8);
        check(pins_oe, 16'h0FCC);
        wr(8'h0F, 8'h0F, 8'h0, 8'h0, 1);
        check(pins_oe, 16'h0000);
        wr(8'h0F, 8'h04, 8'h0, 8'h0, 1);
        wr(8'h0E, 8'h00, 8'h0, 8'h0, 1);
        check({15'h0, irq_oe}, 16'h1);
        wr(8'h0E, 8'hF8, 8'h0, 8'h0, 1);
        check({14'h0, irq_oe, standby}, 16'h0);
        check(pins_oe, 16'h0FCC);
        wr(8'h0E, 8'h08, 8'h0, 8'h0, 1);
        check({15'h0, standby}, 16'h1);
        u_mst.frame(1'b0);
        send({dev, 1'b0}, 1'b1);
        send(8'h02, 1'b1);
        reset = 1'b1;
        cyc(5);
        reset = 1'b0;
        u_mst.frame(1'b1);
        check(pins_oe, 16'h0);
        rd(8'h0F, 1'b1, 1);
        check({8'h0, r0 & 8'hBF}, 16'h000C);
        give_verdict();
    end
    initial begin
        #360000;
        failures++;
        give_verdict();
    end
endmodule
